// ===== design/pdfx_pkg.sv
// package: operation codes, exception classes and eligibility masks for the exception map
package pdfx_pkg;
    // exception class bit positions
    localparam int unsigned EXC_W = 6;
    localparam int unsigned EXC_INV = 0;
    localparam int unsigned EXC_DEN = 1;
    localparam int unsigned EXC_DBZ = 2;
    localparam int unsigned EXC_OVF = 3;
    localparam int unsigned EXC_UNF = 4;
    localparam int unsigned EXC_PRE = 5;

    // integer status flag layout for the compare result
    localparam int unsigned CMPF_W = 3;
    localparam int unsigned CMPF_ZERO = 0;
    localparam int unsigned CMPF_PAR = 1;
    localparam int unsigned CMPF_CARRY = 2;

    localparam int unsigned DATA_W = 128;

    typedef enum logic [3:0] {
        PDFX_OP_NONE,
        PDFX_OP_PACKED_DOUBLE_MULTIPLY,
        PDFX_OP_SCALAR_DOUBLE_MULTIPLY,
        PDFX_OP_PACKED_DOUBLE_SQUARE_ROOT,
        PDFX_OP_SCALAR_DOUBLE_SQUARE_ROOT,
        PDFX_OP_UNORDERED_SCALAR_DOUBLE_COMPARE,
        PDFX_OP_UNALIGNED_PACKED_DOUBLE_MOVE,
        PDFX_OP_PACKED_DOUBLE_BITWISE_OR,
        PDFX_OP_PACKED_DOUBLE_BITWISE_XOR,
        PDFX_OP_HIGH_INTERLEAVE,
        PDFX_OP_LOW_INTERLEAVE
    } pdfx_op_t;

    // eligibility masks, bit order {pre, unf, ovf, dbz, den, inv}
    localparam logic [EXC_W-1:0] MASK_MUL = 6'h3b;
    localparam logic [EXC_W-1:0] MASK_SQRT = 6'h23;
    localparam logic [EXC_W-1:0] MASK_CMP = 6'h03;
    localparam logic [EXC_W-1:0] MASK_NONE = 6'h00;
    localparam logic [EXC_W-1:0] FLAGS_RST = 6'h00;
    localparam logic [CMPF_W-1:0] CMPF_RST = 3'h0;
    localparam logic [CMPF_W-1:0] CMPF_UNORD = 3'h7;
    localparam logic [CMPF_W-1:0] CMPF_LESS = 3'h4;
    localparam logic [CMPF_W-1:0] CMPF_EQUAL = 3'h1;
    localparam logic [CMPF_W-1:0] CMPF_GREATER = 3'h0;
endpackage

// ===== design/pdfx_elig_decode.sv
// eligibility mask lookup for one decoded operation
`timescale 1ns/1ps
`default_nettype none
module pdfx_elig_decode
    import pdfx_pkg::*;
(
    // decoded operation
    input wire pdfx_op_t op,
    // allowed exception classes
    output logic [EXC_W-1:0] allow_mask
);
    always_comb begin
        case (op)
            PDFX_OP_PACKED_DOUBLE_MULTIPLY: allow_mask = MASK_MUL; // RULE1
            PDFX_OP_SCALAR_DOUBLE_MULTIPLY: allow_mask = MASK_MUL; // RULE2
            PDFX_OP_PACKED_DOUBLE_SQUARE_ROOT: allow_mask = MASK_SQRT; // RULE3
            PDFX_OP_SCALAR_DOUBLE_SQUARE_ROOT: allow_mask = MASK_SQRT; // RULE4
            PDFX_OP_UNORDERED_SCALAR_DOUBLE_COMPARE: allow_mask = MASK_CMP; // RULE5
            PDFX_OP_UNALIGNED_PACKED_DOUBLE_MOVE: allow_mask = MASK_NONE; // RULE6
            PDFX_OP_PACKED_DOUBLE_BITWISE_OR: allow_mask = MASK_NONE; // RULE7
            PDFX_OP_PACKED_DOUBLE_BITWISE_XOR: allow_mask = MASK_NONE; // RULE8
            PDFX_OP_HIGH_INTERLEAVE: allow_mask = MASK_NONE; // RULE9
            PDFX_OP_LOW_INTERLEAVE: allow_mask = MASK_NONE; // RULE10
            // unknown codes are treated as raising nothing, the safe side
            default: allow_mask = MASK_NONE;
        endcase
    end
endmodule
`default_nettype wire

// ===== design/pdfx_exc_map.sv
// exception eligibility, sticky status and compare flags for the double-precision ops
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE1: packed double multiply may flag invalid, denormal, overflow, underflow, precision, never divide-by-zero.
// RULE2: scalar double multiply may flag invalid, denormal, overflow, underflow, precision, never divide-by-zero.
// RULE3: packed double square root may flag only invalid, denormal and precision.
// RULE4: scalar double square root may flag only invalid, denormal and precision.
// RULE5: unordered scalar double compare sets integer flags from the low elements and may flag only invalid and denormal.
// RULE6: unaligned packed double move carries 128 bits either way and flags nothing.
// RULE7: packed double bitwise or combines 128 bits and flags nothing.
// RULE8: packed double bitwise xor combines 128 bits and flags nothing.
// RULE9: high interleave takes the upper halves of both operands and flags nothing.
// RULE10: low interleave takes the lower halves of both operands and flags nothing.
// RULE11: a detected allowed condition sets its sticky flag, and no-exception ops leave all flags alone.
module pdfx_exc_map
    import pdfx_pkg::*;
#(
    parameter int unsigned DW = DATA_W
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // operation from decoder and datapath
    input wire logic op_valid,
    input wire pdfx_op_t op_code,
    input wire logic [EXC_W-1:0] det_exc,
    input wire logic [DW-1:0] src_a,
    input wire logic [DW-1:0] src_b,
    input wire logic cmp_unord,
    input wire logic cmp_less,
    input wire logic cmp_equal,
    // sticky status clear from exception logic
    input wire logic status_clr,
    // results to exception and status logic
    output logic exc_valid,
    output logic [EXC_W-1:0] exc_raised,
    output logic [EXC_W-1:0] exc_sticky,
    output logic [CMPF_W-1:0] int_flags,
    output logic int_flags_upd,
    output logic [DW-1:0] data_out
);
    localparam int unsigned HW = DW / 2;

    logic [EXC_W-1:0] allow_mask;
    logic [EXC_W-1:0] gated;
    logic exc_valid_q, exc_valid_d;
    logic [EXC_W-1:0] raised_q, raised_d;
    logic [EXC_W-1:0] sticky_q, sticky_d;
    logic [CMPF_W-1:0] flags_q, flags_d;
    logic flags_upd_q, flags_upd_d;
    logic [DW-1:0] data_q, data_d;

    pdfx_elig_decode u_decode (
        .op(op_code),
        .allow_mask(allow_mask)
    );

    // disallowed classes are dropped even if the datapath reports them
    assign gated = op_valid ? (det_exc & allow_mask) : MASK_NONE; // RULE1 RULE2 RULE3 RULE4

    always_comb begin
        exc_valid_d = op_valid;
        raised_d = gated;
        // set wins over a clear in the same cycle
        sticky_d = (status_clr ? FLAGS_RST : sticky_q) | gated; // RULE11
        flags_d = flags_q;
        flags_upd_d = 1'b0;
        data_d = data_q;
        if (op_valid) begin
            case (op_code)
                PDFX_OP_UNORDERED_SCALAR_DOUBLE_COMPARE: begin
                    flags_upd_d = 1'b1;
                    if (cmp_unord) begin
                        flags_d = CMPF_UNORD; // RULE5
                    end else if (cmp_less) begin
                        flags_d = CMPF_LESS; // RULE5
                    end else if (cmp_equal) begin
                        flags_d = CMPF_EQUAL; // RULE5
                    end else begin
                        flags_d = CMPF_GREATER; // RULE5
                    end
                end
                PDFX_OP_UNALIGNED_PACKED_DOUBLE_MOVE: begin
                    data_d = src_b; // RULE6
                end
                PDFX_OP_PACKED_DOUBLE_BITWISE_OR: begin
                    data_d = src_a | src_b; // RULE7
                end
                PDFX_OP_PACKED_DOUBLE_BITWISE_XOR: begin
                    data_d = src_a ^ src_b; // RULE8
                end
                PDFX_OP_HIGH_INTERLEAVE: begin
                    data_d = {src_b[DW-1:HW], src_a[DW-1:HW]}; // RULE9
                end
                PDFX_OP_LOW_INTERLEAVE: begin
                    data_d = {src_b[HW-1:0], src_a[HW-1:0]}; // RULE10
                end
                default: begin
                    data_d = data_q;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            exc_valid_q <= 1'b0;
            raised_q <= FLAGS_RST;
            sticky_q <= FLAGS_RST;
            flags_q <= CMPF_RST;
            flags_upd_q <= 1'b0;
            data_q <= '0;
        end else begin
            exc_valid_q <= exc_valid_d;
            raised_q <= raised_d;
            sticky_q <= sticky_d;
            flags_q <= flags_d;
            flags_upd_q <= flags_upd_d;
            data_q <= data_d;
        end
    end

    assign exc_valid = exc_valid_q;
    assign exc_raised = raised_q;
    assign exc_sticky = sticky_q;
    assign int_flags = flags_q;
    assign int_flags_upd = flags_upd_q;
    assign data_out = data_q;

    // operand halves, named so the checks can take their past values
    logic [HW-1:0] src_a_hi;
    logic [HW-1:0] src_a_lo;
    logic [HW-1:0] src_b_hi;
    logic [HW-1:0] src_b_lo;
    assign src_a_hi = src_a[DW-1:HW];
    assign src_a_lo = src_a[HW-1:0];
    assign src_b_hi = src_b[DW-1:HW];
    assign src_b_lo = src_b[HW-1:0];

    // checks
    sequence cmp_issue_s;
        op_valid && op_code == PDFX_OP_UNORDERED_SCALAR_DOUBLE_COMPARE;
    endsequence

    sequence mul_issue_s;
        op_valid && (op_code == PDFX_OP_PACKED_DOUBLE_MULTIPLY
            || op_code == PDFX_OP_SCALAR_DOUBLE_MULTIPLY);
    endsequence

    sequence sqrt_issue_s;
        op_valid && (op_code == PDFX_OP_PACKED_DOUBLE_SQUARE_ROOT
            || op_code == PDFX_OP_SCALAR_DOUBLE_SQUARE_ROOT);
    endsequence

    sequence quiet_issue_s;
        op_valid && allow_mask == MASK_NONE;
    endsequence

    mul_no_dbz_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE1
        mul_issue_s |=> !raised_q[EXC_DBZ] && raised_q == ($past(det_exc) & MASK_MUL))
        else $error("multiply raised a class it may not");
    smul_pass_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE2
        (op_valid && op_code == PDFX_OP_SCALAR_DOUBLE_MULTIPLY && det_exc[EXC_OVF])
        |=> raised_q[EXC_OVF] && sticky_q[EXC_OVF])
        else $error("scalar multiply overflow lost");
    sqrt_limit_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE3
        sqrt_issue_s |=> (raised_q & ~MASK_SQRT) == MASK_NONE)
        else $error("square root raised a forbidden class");
    ssqrt_pass_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE4
        (op_valid && op_code == PDFX_OP_SCALAR_DOUBLE_SQUARE_ROOT)
        |=> raised_q == ($past(det_exc) & MASK_SQRT))
        else $error("scalar square root classes wrong");
    cmp_flags_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE5
        (op_valid && op_code == PDFX_OP_UNORDERED_SCALAR_DOUBLE_COMPARE && cmp_unord)
        |=> int_flags_upd && int_flags == CMPF_UNORD && (raised_q & ~MASK_CMP) == MASK_NONE)
        else $error("compare flags or classes wrong");
    move_data_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE6
        (op_valid && op_code == PDFX_OP_UNALIGNED_PACKED_DOUBLE_MOVE)
        |=> data_out == $past(src_b) && raised_q == MASK_NONE)
        else $error("move data or classes wrong");
    xor_data_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE8
        (op_valid && op_code == PDFX_OP_PACKED_DOUBLE_BITWISE_XOR)
        |=> data_out == ($past(src_a) ^ $past(src_b)))
        else $error("xor result wrong");
    high_ilv_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE9
        (op_valid && op_code == PDFX_OP_HIGH_INTERLEAVE)
        |=> data_out == {$past(src_b_hi), $past(src_a_hi)})
        else $error("high interleave wrong");
    quiet_keep_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE11
        (quiet_issue_s and !status_clr) |=> $stable(sticky_q))
        else $error("quiet op touched sticky flags");
    or_data_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE7
        (op_valid && op_code == PDFX_OP_PACKED_DOUBLE_BITWISE_OR)
        |=> data_out == ($past(src_a) | $past(src_b)) && raised_q == MASK_NONE)
        else $error("or result or classes wrong");
    low_ilv_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE10
        (op_valid && op_code == PDFX_OP_LOW_INTERLEAVE)
        |=> data_out == {$past(src_b_lo), $past(src_a_lo)})
        else $error("low interleave wrong");
    sticky_set_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE11
        op_valid |=> (sticky_q & $past(gated)) == $past(gated))
        else $error("detected class missing from sticky flags");
    cmp_less_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE5
        (cmp_issue_s and (!cmp_unord && cmp_less)) |=> int_flags_upd && int_flags == CMPF_LESS)
        else $error("compare less flags wrong");
    cmp_equal_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE5
        (cmp_issue_s and (!cmp_unord && !cmp_less && cmp_equal)) |=> int_flags == CMPF_EQUAL)
        else $error("compare equal flags wrong");
    // flags must hold between compares so a late reader still sees the last result
    flags_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE5
        !(op_valid && op_code == PDFX_OP_UNORDERED_SCALAR_DOUBLE_COMPARE)
        |=> !int_flags_upd && $stable(int_flags))
        else $error("flags moved without a compare");
    quiet_none_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE8 RULE9 RULE10
        quiet_issue_s |=> raised_q == MASK_NONE)
        else $error("quiet op raised a class");
endmodule
`default_nettype wire

// ===== test/pdfx_dp_model.sv
// behavioural decoder and datapath model feeding the exception map
`timescale 1ns/1ps
`default_nettype none
module pdfx_dp_model
    import pdfx_pkg::*;
(
    // clock and requests from the bench
    input wire logic core_clk,
    input wire logic req_v,
    input wire pdfx_op_t req_op,
    input wire logic [EXC_W-1:0] req_exc,
    input wire logic [DATA_W-1:0] req_a,
    input wire logic [DATA_W-1:0] req_b,
    input wire logic [2:0] req_cmp,
    // operation to the exception map
    output var logic op_valid,
    output var pdfx_op_t op_code,
    output var logic [EXC_W-1:0] det_exc,
    output var logic [DATA_W-1:0] src_a,
    output var logic [DATA_W-1:0] src_b,
    output var logic [2:0] cmp_bits
);
    initial begin
        op_valid = 1'b0;
        op_code = PDFX_OP_NONE;
        det_exc = 6'h00;
        src_a = '0;
        src_b = '0;
        cmp_bits = 3'h0;
    end
    // det_exc, operand and compare lines flip every idle cycle, op_code holds, so a design that ignores op_valid is seen
    always @(negedge core_clk) begin
        op_valid <= req_v;
        if (req_v) begin
            op_code <= req_op;
            det_exc <= req_exc;
            src_a <= req_a;
            src_b <= req_b;
            cmp_bits <= req_cmp;
        end else begin
            det_exc <= ~det_exc;
            src_a <= ~src_a;
            src_b <= ~src_b;
            cmp_bits <= ~cmp_bits;
        end
    end
endmodule
`default_nettype wire

// ===== test/tb_packed_double_fp_exception_map.sv
// self-checking bench for the double-precision exception map
`timescale 1ns/1ps
`default_nettype none
module tb_packed_double_fp_exception_map;
    import pdfx_pkg::*;
    logic core_clk, rst_b, status_clr, req_v;
    pdfx_op_t req_op;
    logic [5:0] req_exc;
    logic [2:0] req_cmp;
    logic [127:0] av, bv;
    wire logic op_valid, exc_valid, upd;
    wire pdfx_op_t op_code;
    wire logic [5:0] det_exc, raised, sticky;
    wire logic [127:0] src_a, src_b, dout;
    wire logic [2:0] cmp_bits, iflags;
    int bad_count = 0;
    int n_checks = 0;
    pdfx_dp_model i_dp (.core_clk(core_clk), .req_v(req_v), .req_op(req_op), .req_exc(req_exc),
        .req_a(av), .req_b(bv), .req_cmp(req_cmp), .op_valid(op_valid), .op_code(op_code),
        .det_exc(det_exc), .src_a(src_a), .src_b(src_b), .cmp_bits(cmp_bits));
    pdfx_exc_map i_dut (.core_clk(core_clk), .rst_b(rst_b), .op_valid(op_valid),
        .op_code(op_code), .det_exc(det_exc), .src_a(src_a), .src_b(src_b),
        .cmp_unord(cmp_bits[2]), .cmp_less(cmp_bits[1]), .cmp_equal(cmp_bits[0]),
        .status_clr(status_clr), .exc_valid(exc_valid), .exc_raised(raised),
        .exc_sticky(sticky), .int_flags(iflags), .int_flags_upd(upd), .data_out(dout));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic end_of_test();
        if (bad_count == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // called just after a rising edge; returns just after the edge that took the op
    // the request stays up so back-to-back calls never touch req_v twice in one step
    task automatic send(input pdfx_op_t op, input logic [5:0] exc, input logic [2:0] cmp);
        req_v = 1'b1;
        req_op = op;
        req_exc = exc;
        req_cmp = cmp;
        @(posedge core_clk);
        #1;
    endtask
    task automatic clr();
        @(negedge core_clk);
        status_clr = 1'b1;
        @(negedge core_clk);
        status_clr = 1'b0;
        @(posedge core_clk);
        #1;
    endtask
    // all classes detected, then only the forbidden ones
    task automatic t_mask(input pdfx_op_t op, input logic [5:0] exp);
        clr();
        send(op, 6'h3f, 3'h0);
        chk("exc_valid", 1, exc_valid);
        chk("exc_raised", exp, raised);
        chk("exc_sticky", exp, sticky);
        send(op, 6'h3f & ~exp, 3'h0);
        chk("exc_raised", 0, raised);
        chk("exc_sticky", exp, sticky);
        req_v = 1'b0;
        @(posedge core_clk);
        #1;
        chk("exc_valid", 0, exc_valid);
    endtask
    // back to back: sticky accumulates, quiet ops leave it alone
    task automatic t_sticky();
        clr();
        send(PDFX_OP_PACKED_DOUBLE_MULTIPLY, 6'h01, 3'h0);
        send(PDFX_OP_UNALIGNED_PACKED_DOUBLE_MOVE, 6'h3f, 3'h0);
        chk("exc_sticky", 6'h01, sticky);
        send(PDFX_OP_SCALAR_DOUBLE_SQUARE_ROOT, 6'h20, 3'h0);
        send(PDFX_OP_HIGH_INTERLEAVE, 6'h3e, 3'h0);
        chk("exc_sticky", 6'h21, sticky);
    endtask
    // clear and a detected class in one cycle: the class ends set, older ones go
    task automatic t_clr_set();
        send(PDFX_OP_PACKED_DOUBLE_MULTIPLY, 6'h01, 3'h0);
        chk("exc_sticky", 6'h21, sticky);
        req_exc = 6'h08;
        @(negedge core_clk);
        status_clr = 1'b1;
        @(posedge core_clk);
        #1;
        chk("exc_sticky", 6'h08, sticky);
        @(negedge core_clk);
        status_clr = 1'b0;
        @(posedge core_clk);
        #1;
    endtask
    task automatic t_cmp(input logic [2:0] cmp, input logic [2:0] exp);
        send(PDFX_OP_UNORDERED_SCALAR_DOUBLE_COMPARE, 6'h00, cmp);
        chk("int_flags_upd", 1, upd);
        chk("int_flags", exp, iflags);
        send(PDFX_OP_SCALAR_DOUBLE_MULTIPLY, 6'h00, ~cmp);
        chk("int_flags_upd", 0, upd);
        chk("int_flags", exp, iflags);
    endtask
    task automatic t_data(input pdfx_op_t op, input logic [127:0] exp);
        send(op, 6'h00, 3'h0);
        chk("data_out", exp, dout);
        send(PDFX_OP_PACKED_DOUBLE_SQUARE_ROOT, 6'h00, 3'h0);
        chk("data_out", exp, dout);
    endtask
    initial begin
        #100000;
        bad_count++;
        end_of_test();
    end
    initial begin
        rst_b = 1'b0;
        status_clr = 1'b0;
        req_v = 1'b0;
        req_op = PDFX_OP_NONE;
        req_exc = 6'h00;
        req_cmp = 3'h0;
        av = 128'h0123456789abcdef_fedcba9876543210;
        bv = 128'h55aa00ff33cc0f0f_c3c3a5a5f00f1234;
        repeat (10) @(negedge core_clk);
        rst_b = 1'b1;
        @(posedge core_clk);
        #1;
        chk("exc_sticky", 0, sticky);
        t_mask(PDFX_OP_PACKED_DOUBLE_MULTIPLY, 6'h3b);
        t_mask(PDFX_OP_SCALAR_DOUBLE_MULTIPLY, 6'h3b);
        t_mask(PDFX_OP_PACKED_DOUBLE_SQUARE_ROOT, 6'h23);
        t_mask(PDFX_OP_SCALAR_DOUBLE_SQUARE_ROOT, 6'h23);
        t_mask(PDFX_OP_UNORDERED_SCALAR_DOUBLE_COMPARE, 6'h03);
        t_mask(PDFX_OP_UNALIGNED_PACKED_DOUBLE_MOVE, 6'h00);
        t_mask(PDFX_OP_PACKED_DOUBLE_BITWISE_OR, 6'h00);
        t_mask(PDFX_OP_PACKED_DOUBLE_BITWISE_XOR, 6'h00);
        t_mask(PDFX_OP_HIGH_INTERLEAVE, 6'h00);
        t_mask(PDFX_OP_LOW_INTERLEAVE, 6'h00);
        t_mask(PDFX_OP_NONE, 6'h00);
        t_sticky();
        t_clr_set();
        t_cmp(3'h7, 3'h7);
        t_cmp(3'h2, 3'h4);
        t_cmp(3'h1, 3'h1);
        t_cmp(3'h0, 3'h0);
        t_data(PDFX_OP_UNALIGNED_PACKED_DOUBLE_MOVE, bv);
        t_data(PDFX_OP_PACKED_DOUBLE_BITWISE_OR, av | bv);
        t_data(PDFX_OP_PACKED_DOUBLE_BITWISE_XOR, av ^ bv);
        t_data(PDFX_OP_HIGH_INTERLEAVE, {bv[127:64], av[127:64]});
        t_data(PDFX_OP_LOW_INTERLEAVE, {bv[63:0], av[63:0]});
        end_of_test();
    end
endmodule
`default_nettype wire
